/* logic/supply_mode_pkg.sv */
// shared constants and carrier types for the supply and mode sequencer
package supply_mode_pkg;
    localparam int          NUM_CH          = 8;
    localparam int          LIMP_CH_A       = 2;
    localparam int          LIMP_CH_B       = 3;
    localparam int          CLK_MHZ         = 100;
    localparam int          TRANS_LAT_NS    = 1000;
    localparam int          TRANS_LAT_CYC   = (TRANS_LAT_NS * CLK_MHZ + 999) / 1000;
    localparam int          SYNC_STAGES     = 2;
    localparam logic [1:0]  MODE_IDLE       = 2'h0;
    localparam logic [1:0]  MODE_LIMP       = 2'h1;
    localparam logic [1:0]  MODE_ACTIVE     = 2'h2;
    localparam logic [1:0]  MODE_SLEEP      = 2'h3;
    localparam logic [7:0]  CH_ALL_OFF      = 8'h00;
    localparam logic [7:0]  DIAG_LIMP_MASK  = 8'h0C;
    localparam logic [7:0]  DIAG_ALL_MASK   = 8'hFF;

    typedef enum logic [4:0] {
        ST_SLEEP  = 5'h01,
        ST_IDLE   = 5'h02,
        ST_WAKE   = 5'h04,
        ST_ACTIVE = 5'h08,
        ST_LIMP   = 5'h10
    } mode_state_t;

    // control pins from the host, raw or synchronised
    typedef struct packed {
        logic standby;
        logic direct_input_1;
        logic direct_input_0;
    } ctrl_pins_t;

    // supply monitor levels
    typedef struct packed {
        logic battery_uv;
        logic io_uv;
        logic int_supply_fail;
    } supply_t;
endpackage

/* logic/pin_sync.sv */
// two-stage synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import supply_mode_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // pins
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic [SYNC_STAGES-1:0] chain;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    chain <= '0;
                end else begin
                    chain <= {chain[SYNC_STAGES-2:0], async_i[g]};
                end
            end
            assign sync_o[g] = chain[SYNC_STAGES-1];
        end
    endgenerate
endmodule
`default_nettype wire

/* logic/status_flags.sv */
// sticky supply, power-on-reset and diagnostic flags
`timescale 1ns/1ps
`default_nettype none
module status_flags
    import supply_mode_pkg::*;
#(
    parameter int N = NUM_CH
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // events
    input  wire supply_t      supply_i,
    input  wire logic         por_cond_i,
    input  wire logic [N-1:0] diag_event_i,
    // host acknowledge and read
    input  wire logic         battery_ack_i,
    input  wire logic         io_ack_i,
    input  wire logic         por_read_i,
    input  wire logic [N-1:0] diag_clear_i,
    // flags
    output logic              battery_undervoltage_flag_o,
    output logic              io_supply_undervoltage_flag_o,
    output logic              power_on_reset_flag_o,
    output logic      [N-1:0] overload_overtemp_diag_o
);
    // set wins over clear everywhere; no register reset reaches these
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            battery_undervoltage_flag_o <= 1'b0;
        end else if (supply_i.battery_uv) begin
            battery_undervoltage_flag_o <= 1'b1;
        end else if (battery_ack_i) begin
            battery_undervoltage_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_supply_undervoltage_flag_o <= 1'b0;
        end else if (supply_i.io_uv && !por_cond_i) begin
            io_supply_undervoltage_flag_o <= 1'b1;
        end else if (io_ack_i) begin
            io_supply_undervoltage_flag_o <= 1'b0;
        end
    end

    // the block's own reset is a power-on condition too
    always_ff @(posedge clk_i) begin
        if (rst_i || por_cond_i) begin
            power_on_reset_flag_o <= 1'b1;
        end else if (por_read_i) begin
            power_on_reset_flag_o <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_diag
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    overload_overtemp_diag_o[g] <= 1'b0;
                end else if (diag_event_i[g]) begin
                    overload_overtemp_diag_o[g] <= 1'b1;
                end else if (diag_clear_i[g]) begin
                    overload_overtemp_diag_o[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* logic/supply_mode_reset_controller.sv */
// operating-mode and reset sequencer for the eight-channel driver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - battery undervoltage flag latched until acknowledged
// - io undervoltage flag when no power-on reset
// - power-on reset sets flag, read clears
// - power-up needs battery and standby or input
// - sleep: outputs off, registers held reset
// - idle: channels off, no on-diagnostics
// - idle keeps overload and overtemperature flags
// - force-active bit holds active mode
// - active needs standby, source and enabled channel
// - no sources, inputs low and force clear returns idle
// - io undervoltage, inputs low, standby: power-on reset to sleep
// - standby low, input high: limp, writes ignored
// - limp: input 0 to ch2, 1 to ch3
// - limp reports mode code 01
// - limp keeps ch2/ch3 overload diagnostics
// - limp from sleep: defaults, channels autoconfigure
// - open-load-on diagnostics only in active
// - four conditions reset read/write registers
// - register reset: only ch2/ch3 by inputs
// - register reset spares diag and supply flags
// - supply failure, or io uv with inputs low, resets logic
// - turn-on outside active/limp adds transition latency
// - battery uv blocks idle to active only with standby and both inputs high
module supply_mode_reset_controller
    import supply_mode_pkg::*;
#(
    parameter int N       = NUM_CH,
    parameter int LAT_CYC = TRANS_LAT_CYC
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control pins and supply monitors
    input  wire ctrl_pins_t   pins_i,
    input  wire supply_t      supply_i,
    input  wire logic         external_reset_pin_i,
    // configuration from the register file
    input  wire logic         force_active_bit_i,
    input  wire logic         soft_reset_i,
    input  wire logic         ext_reset_sense_i,
    input  wire logic [N-1:0] spi_output_command_i,
    input  wire logic [N-1:0] channel_enable_i,
    input  wire logic [N-1:0] first_input_routing_i,
    input  wire logic [N-1:0] second_input_routing_i,
    input  wire logic [N-1:0] pwm_routed_i,
    input  wire logic [1:0]   pwm_gen_on_i,
    input  wire logic [N-1:0] open_load_on_diag_enable_i,
    // diagnostics from the channels
    input  wire logic [N-1:0] overload_overtemp_event_i,
    // host acknowledge and read strobes
    input  wire logic         battery_ack_i,
    input  wire logic         io_ack_i,
    input  wire logic         por_read_i,
    input  wire logic [N-1:0] diag_clear_i,
    // mode and resets
    output logic [1:0]        mode_o,
    output logic              register_reset_o,
    output logic              logic_reset_o,
    output logic              spi_write_allow_o,
    output logic              on_diag_allow_o,
    output logic              limp_autoconfig_o,
    // channel control
    output logic [N-1:0]      channel_on_o,
    output logic [N-1:0]      open_load_on_run_o,
    // status flags
    output logic              battery_undervoltage_flag_o,
    output logic              io_supply_undervoltage_flag_o,
    output logic              power_on_reset_flag_o,
    output logic [N-1:0]      overload_overtemp_diag_o
);
    localparam int CW = $clog2(LAT_CYC + 1);
    localparam logic [CW-1:0] LAT_LAST = CW'(LAT_CYC - 1);

    ctrl_pins_t  pin;
    mode_state_t state;
    mode_state_t next_state;
    mode_state_t wake_target;
    mode_state_t next_target;
    logic [CW-1:0] wake_cnt;
    logic        any_in;
    logic        sleep_cond;
    logic        limp_cond;
    logic        source_any;
    logic        active_req;
    logic        idle_force;
    logic        reg_reset_cond;
    logic        por_cond;
    logic        limp_from_sleep;
    logic [N-1:0] diag_gate;
    logic [N-1:0] ch_limp;
    logic [N-1:0] ch_cmd;

    pin_sync #(
        .WIDTH ($bits(ctrl_pins_t))
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pins_i),
        .sync_o  (pin)
    );

    assign any_in     = pin.direct_input_0 | pin.direct_input_1;
    assign sleep_cond = !pin.standby && !any_in;
    assign limp_cond  = !pin.standby && any_in;
    // routed inputs only count as a source while the pin is high
    assign source_any = (|spi_output_command_i) | (|pwm_gen_on_i) | (|pwm_routed_i)
                      | ((|first_input_routing_i) & pin.direct_input_0)
                      | ((|second_input_routing_i) & pin.direct_input_1);
    assign active_req = force_active_bit_i
                      | (pin.standby && source_any && (|channel_enable_i));
    assign idle_force = pin.standby && supply_i.io_uv && !any_in;
    assign por_cond   = supply_i.int_supply_fail || (supply_i.io_uv && !any_in);
    assign reg_reset_cond = supply_i.io_uv || sleep_cond || soft_reset_i
                          || (external_reset_pin_i && ext_reset_sense_i);

    // mode transitions
    always_comb begin
        next_state  = state;
        next_target = wake_target;
        case (state)
            ST_SLEEP: begin
                if (!supply_i.battery_uv && (pin.standby || any_in)) begin
                    next_state  = ST_WAKE;
                    next_target = limp_cond ? ST_LIMP : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (sleep_cond) begin
                    next_state = ST_SLEEP;
                end else if (limp_cond) begin
                    next_state  = ST_WAKE;
                    next_target = ST_LIMP;
                end else if (active_req && !idle_force
                             && !(supply_i.battery_uv && pin.standby && pin.direct_input_0
                                  && pin.direct_input_1)) begin
                    next_state  = ST_WAKE;
                    next_target = ST_ACTIVE;
                end
            end
            ST_WAKE: begin
                if (sleep_cond) begin
                    next_state = ST_SLEEP;
                end else if (wake_cnt == LAT_LAST) begin
                    next_state = wake_target;
                end
            end
            ST_ACTIVE: begin
                if (sleep_cond) begin
                    next_state = ST_SLEEP;
                end else if (limp_cond) begin
                    next_state = ST_LIMP;
                end else if (idle_force) begin
                    next_state = ST_IDLE;
                end else if (!force_active_bit_i && !source_any && !any_in) begin
                    next_state = ST_IDLE;
                end
            end
            ST_LIMP: begin
                if (sleep_cond) begin
                    next_state = ST_SLEEP;
                end else if (pin.standby) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_cond) begin
            state       <= ST_SLEEP;
            wake_target <= ST_IDLE;
        end else begin
            state       <= next_state;
            wake_target <= next_target;
        end
    end

    // latency counter runs only while waking
    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_WAKE) begin
            wake_cnt <= '0;
        end else if (wake_cnt != LAT_LAST) begin
            wake_cnt <= wake_cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_cond) begin
            limp_from_sleep <= 1'b0;
        end else if (state == ST_SLEEP) begin
            limp_from_sleep <= 1'b1;
        end else if (state == ST_ACTIVE || state == ST_IDLE) begin
            limp_from_sleep <= 1'b0;
        end
    end

    // channel commands per mode
    always_comb begin
        ch_limp            = CH_ALL_OFF;
        ch_limp[LIMP_CH_A] = pin.direct_input_0;
        ch_limp[LIMP_CH_B] = pin.direct_input_1;
        ch_cmd = CH_ALL_OFF;
        case (state)
            ST_ACTIVE: begin
                if (register_reset_o) begin
                    ch_cmd = ch_limp;
                end else begin
                    ch_cmd = channel_enable_i & (spi_output_command_i | pwm_routed_i
                           | (first_input_routing_i & {N{pin.direct_input_0}})
                           | (second_input_routing_i & {N{pin.direct_input_1}}));
                end
            end
            ST_LIMP: begin
                ch_cmd = ch_limp;
            end
            default: begin
                ch_cmd = CH_ALL_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_on_o       <= CH_ALL_OFF;
            open_load_on_run_o <= CH_ALL_OFF;
            on_diag_allow_o    <= 1'b0;
        end else begin
            channel_on_o       <= ch_cmd;
            open_load_on_run_o <= (state == ST_ACTIVE) ? open_load_on_diag_enable_i : CH_ALL_OFF;
            on_diag_allow_o    <= (state == ST_ACTIVE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= MODE_SLEEP;
        end else begin
            case (state)
                ST_LIMP:   mode_o <= MODE_LIMP;
                ST_ACTIVE: mode_o <= MODE_ACTIVE;
                ST_SLEEP:  mode_o <= MODE_SLEEP;
                default:   mode_o <= MODE_IDLE;
            endcase
        end
    end

    // resets and write permission
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            register_reset_o  <= 1'b1;
            logic_reset_o     <= 1'b1;
            spi_write_allow_o <= 1'b0;
            limp_autoconfig_o <= 1'b0;
        end else begin
            register_reset_o  <= reg_reset_cond || (state == ST_SLEEP);
            logic_reset_o     <= por_cond;
            spi_write_allow_o <= !supply_i.io_uv && !reg_reset_cond
                              && (state == ST_IDLE || state == ST_ACTIVE || state == ST_WAKE);
            limp_autoconfig_o <= (state == ST_LIMP) && limp_from_sleep;
        end
    end

    // idle, wake and sleep record no new diagnostics; limp watches ch2/ch3 only
    always_comb begin
        case (state)
            ST_ACTIVE: diag_gate = DIAG_ALL_MASK;
            ST_LIMP:   diag_gate = DIAG_LIMP_MASK;
            default:   diag_gate = CH_ALL_OFF;
        endcase
    end

    status_flags #(
        .N (N)
    ) u_status_flags (
        .clk_i                         (clk_i),
        .rst_i                         (rst_i),
        .supply_i                      (supply_i),
        .por_cond_i                    (por_cond),
        .diag_event_i                  (overload_overtemp_event_i & diag_gate),
        .battery_ack_i                 (battery_ack_i && spi_write_allow_o),
        .io_ack_i                      (io_ack_i && spi_write_allow_o),
        .por_read_i                    (por_read_i),
        .diag_clear_i                  (diag_clear_i & {N{spi_write_allow_o}}),
        .battery_undervoltage_flag_o   (battery_undervoltage_flag_o),
        .io_supply_undervoltage_flag_o (io_supply_undervoltage_flag_o),
        .power_on_reset_flag_o         (power_on_reset_flag_o),
        .overload_overtemp_diag_o      (overload_overtemp_diag_o)
    );
endmodule
`default_nettype wire

/* bench/supply_mode_reset_controller_sva.sv */
// assertion checker for the supply and mode sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_mode_reset_controller_sva
    import supply_mode_pkg::*;
#(
    parameter int N       = NUM_CH,
    parameter int LAT_CYC = TRANS_LAT_CYC
) (
    // clock and reset
    input wire logic         clk_i,
    input wire logic         rst_i,
    // watched inputs
    input wire supply_t      supply_i,
    input wire logic         soft_reset_i,
    input wire logic         battery_ack_i,
    input wire logic         io_ack_i,
    // watched outputs
    input wire logic [1:0]   mode_o,
    input wire logic         register_reset_o,
    input wire logic         logic_reset_o,
    input wire logic         spi_write_allow_o,
    input wire logic         on_diag_allow_o,
    input wire logic [N-1:0] channel_on_o,
    input wire logic [N-1:0] open_load_on_run_o,
    input wire logic         battery_undervoltage_flag_o,
    input wire logic         io_supply_undervoltage_flag_o,
    input wire logic         power_on_reset_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // mode_o and channel_on_o register the same state, so they move together
    property p_limp_ch; mode_o == MODE_LIMP |-> (channel_on_o & ~DIAG_LIMP_MASK) == CH_ALL_OFF; endproperty
    a_limp_ch: assert property (p_limp_ch) else $error("channel outside limp pair on");
    property p_sleep_off; mode_o == MODE_SLEEP |-> channel_on_o == CH_ALL_OFF; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep");
    property p_idle_off; mode_o == MODE_IDLE |-> channel_on_o == CH_ALL_OFF; endproperty
    a_idle_off: assert property (p_idle_off) else $error("channel on in idle");
    property p_limp_ro; mode_o == MODE_LIMP && $past(mode_o) == MODE_LIMP |-> !$past(spi_write_allow_o); endproperty
    a_limp_ro: assert property (p_limp_ro) else $error("writes allowed in limp");
    property p_limp_no_ol;
        mode_o == MODE_LIMP && $past(mode_o) == MODE_LIMP |-> open_load_on_run_o == '0 && !$past(on_diag_allow_o);
    endproperty
    a_limp_no_ol: assert property (p_limp_no_ol) else $error("on-state diagnosis in limp");
    property p_batt_set; $rose(supply_i.battery_uv) |-> ##[1:3] battery_undervoltage_flag_o; endproperty
    a_batt_set: assert property (p_batt_set) else $error("battery flag not set");
    property p_batt_hold; battery_undervoltage_flag_o && !battery_ack_i |=> battery_undervoltage_flag_o; endproperty
    a_batt_hold: assert property (p_batt_hold) else $error("battery flag lost");
    property p_io_hold; io_supply_undervoltage_flag_o && !io_ack_i |=> io_supply_undervoltage_flag_o; endproperty
    a_io_hold: assert property (p_io_hold) else $error("io flag lost");
    property p_por_set; $rose(supply_i.int_supply_fail) |-> ##[1:4] power_on_reset_flag_o; endproperty
    a_por_set: assert property (p_por_set) else $error("power-on flag not set");
    property p_logic_rst; supply_i.int_supply_fail |-> ##[1:4] logic_reset_o; endproperty
    a_logic_rst: assert property (p_logic_rst) else $error("logic reset missing");
    property p_soft_rst; soft_reset_i |-> ##[1:3] register_reset_o; endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("register reset missing");

    c_limp: cover property (mode_o == MODE_LIMP);
    c_active: cover property (mode_o == MODE_ACTIVE);
    c_por: cover property (power_on_reset_flag_o && !logic_reset_o);
endmodule

bind supply_mode_reset_controller supply_mode_reset_controller_sva #(.N(N), .LAT_CYC(LAT_CYC)) sva_i (
    .clk_i(clk_i), .rst_i(rst_i), .supply_i(supply_i), .soft_reset_i(soft_reset_i),
    .battery_ack_i(battery_ack_i), .io_ack_i(io_ack_i), .mode_o(mode_o), .register_reset_o(register_reset_o),
    .logic_reset_o(logic_reset_o), .spi_write_allow_o(spi_write_allow_o), .on_diag_allow_o(on_diag_allow_o),
    .channel_on_o(channel_on_o), .open_load_on_run_o(open_load_on_run_o),
    .battery_undervoltage_flag_o(battery_undervoltage_flag_o),
    .io_supply_undervoltage_flag_o(io_supply_undervoltage_flag_o), .power_on_reset_flag_o(power_on_reset_flag_o)
);
`default_nettype wire

/* bench/host_control_model.sv */
// host microcontroller model driving pins and configuration
`timescale 1ns/1ps
`default_nettype none
module host_control_model
    import supply_mode_pkg::*;
(
    // clock and observed mode
    input  wire logic       clk_i,
    input  wire logic [1:0] mode_i,
    // pins and configuration
    output var ctrl_pins_t  pins_o,
    output logic            force_active_o,
    output logic            soft_reset_o,
    output logic [7:0]      spi_cmd_o,
    output logic [7:0]      enable_o,
    output logic [7:0]      routing_o
);
    initial begin
        pins_o = '0;
        force_active_o = 1'b0;
        soft_reset_o = 1'b0;
        spi_cmd_o = 8'h00;
        enable_o = 8'h00;
        routing_o = 8'h00;
    end

    task automatic apply(input logic [2:0] p, input logic f, s, input logic [7:0] c, e, r);
        @(negedge clk_i);
        // pins alone may leave the drivers on when dropping out of active
        soft_reset_o = s | (mode_i == MODE_ACTIVE && p == 3'h0);
        pins_o = p;
        force_active_o = f;
        spi_cmd_o = c;
        enable_o = e;
        routing_o = r;
        @(negedge clk_i);
        soft_reset_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* bench/supply_mode_reset_controller_test.sv */
// self-checking testbench for the supply and mode sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_mode_reset_controller_test;
    import supply_mode_pkg::*;
    localparam int LAT = 2;
    typedef struct packed {
        logic [2:0] p; logic f; logic [7:0] c, e, r; logic [1:0] m; logic [7:0] ch;
    } row_t;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    supply_t    supply = '0;
    logic       ext_pin = 1'b0, batt_ack = 1'b0, por_read = 1'b0, io_ack = 1'b0;
    logic [7:0] ovl_ev = 8'h00, diag_clr = 8'h00;
    ctrl_pins_t pins;
    logic       force_act, soft_rst, reg_rst, log_rst, wr_allow, autocfg, b_flag, io_flag, por_flag;
    logic [7:0] cmd, en, route, ch_on, diag;
    logic [1:0] mode;
    int         err_total = 0, checks_done = 0, n;
    row_t rows [9] = '{
        '{3'h4, 1'b1, 8'h00, 8'hFF, 8'h00, MODE_ACTIVE, 8'h00}, '{3'h4, 1'b0, 8'h11, 8'h01, 8'h00, MODE_ACTIVE, 8'h01},
        '{3'h0, 1'b0, 8'h00, 8'h00, 8'h00, MODE_SLEEP, 8'h00}, '{3'h1, 1'b0, 8'h00, 8'h00, 8'h00, MODE_LIMP, 8'h04},
        '{3'h3, 1'b0, 8'h00, 8'h00, 8'h00, MODE_LIMP, 8'h0C}, '{3'h2, 1'b0, 8'h00, 8'h00, 8'h00, MODE_LIMP, 8'h08},
        '{3'h4, 1'b0, 8'h00, 8'h00, 8'h00, MODE_IDLE, 8'h00}, '{3'h5, 1'b0, 8'h00, 8'h01, 8'h01, MODE_ACTIVE, 8'h01},
        '{3'h4, 1'b0, 8'h80, 8'h80, 8'h00, MODE_ACTIVE, 8'h80}};

    host_control_model host (.clk_i(clk_i), .mode_i(mode), .pins_o(pins), .force_active_o(force_act),
        .soft_reset_o(soft_rst), .spi_cmd_o(cmd), .enable_o(en), .routing_o(route));

    supply_mode_reset_controller #(.LAT_CYC(LAT)) uut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
        .supply_i(supply), .external_reset_pin_i(ext_pin), .force_active_bit_i(force_act),
        .soft_reset_i(soft_rst), .ext_reset_sense_i(1'b1), .spi_output_command_i(cmd), .channel_enable_i(en),
        .first_input_routing_i(route), .second_input_routing_i(8'h00), .pwm_routed_i(8'h00),
        .pwm_gen_on_i(2'h0), .open_load_on_diag_enable_i(8'hFF), .overload_overtemp_event_i(ovl_ev),
        .battery_ack_i(batt_ack), .io_ack_i(io_ack), .por_read_i(por_read), .diag_clear_i(diag_clr),
        .mode_o(mode), .register_reset_o(reg_rst), .logic_reset_o(log_rst), .spi_write_allow_o(wr_allow),
        .on_diag_allow_o(), .limp_autoconfig_o(autocfg), .channel_on_o(ch_on), .open_load_on_run_o(),
        .battery_undervoltage_flag_o(b_flag), .io_supply_undervoltage_flag_o(io_flag),
        .power_on_reset_flag_o(por_flag), .overload_overtemp_diag_o(diag));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // bounded wait; the count also measures transition latency
    task automatic wait_mode(input logic [1:0] m);
        n = 0;
        while (mode !== m && n < 80) begin
            @(negedge clk_i);
            n++;
        end
        repeat (3) @(negedge clk_i);
    endtask

    task automatic cycle_pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (4) @(negedge clk_i);
        check(mode, MODE_SLEEP, "reset mode");
        check(reg_rst, 1'b1, "reset regs");
        check(por_flag, 1'b1, "reset por flag");
        rst_i = 1'b0;
        $display("test reset done");
        foreach (rows[i]) begin
            host.apply(rows[i].p, rows[i].f, 1'b0, rows[i].c, rows[i].e, rows[i].r);
            wait_mode(rows[i].m);
            check(mode, rows[i].m, "mode");
            check(ch_on, rows[i].ch, "channels");
            check(wr_allow, rows[i].m inside {MODE_IDLE, MODE_ACTIVE}, "write allow");
            if (rows[i].m == MODE_LIMP)
                check(autocfg, 1'b1, "autoconfig");
            $display("test row %0d done", i);
        end
        ovl_ev = 8'h80;
        @(negedge clk_i);
        ovl_ev = 8'h00;
        @(negedge clk_i);
        supply.battery_uv = 1'b1;
        @(negedge clk_i);
        supply.battery_uv = 1'b0;
        repeat (3) @(negedge clk_i);
        host.apply(3'h4, 1'b0, 1'b1, 8'h80, 8'h80, 8'h00);
        repeat (3) @(negedge clk_i);
        check(b_flag, 1'b1, "battery flag kept");
        check(diag, 8'h80, "diag kept");
        check(io_flag, 1'b0, "io flag");
        cycle_pulse(batt_ack);
        check(b_flag, 1'b0, "battery ack");
        ext_pin = 1'b1;
        repeat (3) @(negedge clk_i);
        check(reg_rst, 1'b1, "external reset");
        ext_pin = 1'b0;
        $display("test flags done");
        host.apply(3'h4, 1'b0, 1'b1, 8'h00, 8'h00, 8'h00);
        wait_mode(MODE_IDLE);
        check(diag, 8'h80, "idle diag kept");
        supply.battery_uv = 1'b1;
        // pins must be through the synchroniser before force is seen
        host.apply(3'h7, 1'b0, 1'b0, 8'h00, 8'hFF, 8'h00);
        host.apply(3'h7, 1'b1, 1'b0, 8'h00, 8'hFF, 8'h00);
        repeat (30) @(negedge clk_i);
        check(mode, MODE_IDLE, "uv blocks active");
        supply.battery_uv = 1'b0;
        wait_mode(MODE_ACTIVE);
        check(mode, MODE_ACTIVE, "active after uv");
        check(n > LAT, 1'b1, "transition latency");
        $display("test battery done");
        // io dip with inputs high: flag but no power-on reset
        supply.io_uv = 1'b1;
        @(negedge clk_i);
        supply.io_uv = 1'b0;
        repeat (3) @(negedge clk_i);
        check(io_flag, 1'b1, "io flag set");
        check(log_rst, 1'b0, "no logic reset");
        cycle_pulse(io_ack);
        check(io_flag, 1'b0, "io ack");
        diag_clr = 8'h80;
        @(negedge clk_i);
        diag_clr = 8'h00;
        @(negedge clk_i);
        check(diag, 8'h00, "diag clear");
        $display("test io done");
        supply.int_supply_fail = 1'b1;
        repeat (4) @(negedge clk_i);
        check(log_rst, 1'b1, "logic reset");
        supply.int_supply_fail = 1'b0;
        repeat (4) @(negedge clk_i);
        check(por_flag, 1'b1, "por flag");
        cycle_pulse(por_read);
        check(por_flag, 1'b0, "por read clears");
        $display("test power-on done");
        end_of_test();
    end
endmodule
`default_nettype wire
